//--- common/pmsc_pkg.sv
// pmsc_pkg: register map, field positions and reset values for the
// power supervision status/control block.
// assumes a 32-bit AHB-Lite register bus, one register per aligned word.
package pmsc_pkg;

  // register byte offsets
  localparam logic [11:0] PMSC_SUPV_OFFS = 12'h000;
  localparam logic [11:0] PMSC_WARN_OFFS = 12'h004;
  localparam logic [11:0] PMSC_ISTA_OFFS = 12'h008;
  localparam logic [11:0] PMSC_IMSK_OFFS = 12'h00C;
  localparam int          PMSC_ADDR_W    = 12;

  // supervision register fields
  localparam int PMSC_UVF_BIT    = 7;
  localparam int PMSC_UVACK_BIT  = 6;
  localparam int PMSC_UVIE_BIT   = 5;
  localparam int PMSC_UVRE_BIT   = 4;
  localparam int PMSC_UVSE_BIT   = 3;
  localparam int PMSC_UVDE_BIT   = 2;
  localparam int PMSC_RSVD_BIT   = 1;
  localparam int PMSC_REFERENCE_BUFFER_ENABLE_BIT   = 0;

  // warning/stop register fields
  localparam int PMSC_SWF_BIT    = 7;
  localparam int PMSC_SWACK_BIT  = 6;
  localparam int PMSC_DTSEL_BIT  = 5;
  localparam int PMSC_WTSEL_BIT  = 4;
  localparam int PMSC_DSF_BIT    = 3;
  localparam int PMSC_DSACK_BIT  = 2;
  localparam int PMSC_DSSEL_BIT  = 0;

  // interrupt status/mask fields
  localparam int PMSC_EV_UV_BIT  = 0;
  localparam int PMSC_EV_SW_BIT  = 1;
  localparam int PMSC_EV_DS_BIT  = 2;
  localparam int PMSC_EV_W       = 3;

  // reset values
  localparam logic [7:0] PMSC_SUPV_RST = 8'h1C;
  localparam logic [7:0] PMSC_WARN_RST = 8'h00;
  localparam logic [PMSC_EV_W-1:0] PMSC_EV_RST = 3'h0;

  // ahb encodings
  localparam logic [1:0] PMSC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] PMSC_HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] PMSC_HSIZE_WORD    = 3'h2;

  // bus transaction latched in the address phase
  typedef struct packed {
    logic                   write;
    logic [PMSC_ADDR_W-1:0] addr;
  } pmsc_req_t;

  // analog/system side inputs after synchronisation
  typedef struct packed {
    logic undervolt;
    logic warning;
    logic deep_exit;
    logic in_stop;
  } pmsc_ana_t;

endpackage

//--- rtl/pmsc_top.sv
// pmsc_top: power supervision status and control registers.
// assumes comparator outputs and stop signals come from other domains;
// one bus clock, synchronous reset split into power-on and other causes.
//
// Operation
// - undervolt flag read-only, set when detector enabled
// - writing one to detect ack clears flag
// - interrupt requested while flag and enable set
// - reset forced when flag sets, enabled
// - stop enable keeps detection running in stop
// - detector enable gates all detect logic
// - reference buffer enable drives buffer output
// - warning flag sets below trip, stays set
// - warning ack clears only without warning present
// - detect threshold select driven to detector
// - warning threshold select driven to comparator
// - power-on clears all, others keep threshold selects
// - deep stop exit flag set on exit
// - writing one to exit ack clears flag
// - deep stop select write-once after reset
// - two supervision bits (reset enable, detector enable) write-once after reset
`timescale 1ns/1ps
`default_nettype none

module pmsc_top
  import pmsc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        por_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hsel_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        undervolt_cmp_i,
  input  wire logic        warning_cmp_i,
  input  wire logic        deep_exit_i,
  input  wire logic        in_stop_i,
  output logic             undervolt_irq_o,
  output logic             undervolt_reset_o,
  output logic             detector_on_o,
  output logic             detect_threshold_o,
  output logic             warning_threshold_o,
  output logic             reference_buffer_o,
  output logic             deep_stop_mode_o,
  output logic             irq_o
);

  // word-level view of the register map
  function automatic logic addr_is(input logic [PMSC_ADDR_W-1:0] a,
                                   input logic [PMSC_ADDR_W-1:0] offs);
    addr_is = (a[PMSC_ADDR_W-1:2] == offs[PMSC_ADDR_W-1:2]);
  endfunction

  function automatic logic in_change(input logic [2:0] s);
    in_change = (s[1] == s[2]);
  endfunction

  // three-stage synchronisers, change accepted when stages 2 and 3 agree
  pmsc_ana_t  ana_raw;
  logic [3:0] sync_s1_reg;
  logic [3:0] sync_s2_reg;
  logic [3:0] sync_s3_reg;
  logic [3:0] sync_q_reg;
  pmsc_ana_t  ana;

  assign ana_raw = '{undervolt: undervolt_cmp_i, warning: warning_cmp_i,
                     deep_exit: deep_exit_i, in_stop: in_stop_i};

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sync_s1_reg <= 4'h0;
      sync_s2_reg <= 4'h0;
      sync_s3_reg <= 4'h0;
    end else begin
      sync_s1_reg <= ana_raw;
      sync_s2_reg <= sync_s1_reg;
      sync_s3_reg <= sync_s2_reg;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          sync_q_reg[gi] <= 1'b0;
        end else if (in_change({sync_s3_reg[gi], sync_s2_reg[gi],
                                1'b0})) begin
          sync_q_reg[gi] <= sync_s2_reg[gi];
        end
      end
    end
  endgenerate

  assign ana = sync_q_reg;

  // ahb-lite slave: address phase latched, zero-wait data phase
  pmsc_req_t req_reg;
  logic      req_valid_reg;
  logic      addr_take;
  logic      wr_en;
  logic [7:0] wbyte;

  assign addr_take = hsel_i && hready_i &&
                     (htrans_i == PMSC_HTRANS_NONSEQ ||
                      htrans_i == PMSC_HTRANS_SEQ);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      req_valid_reg <= 1'b0;
      req_reg       <= '0;
    end else if (hready_i) begin
      req_valid_reg <= addr_take;
      req_reg       <= '{write: hwrite_i, addr: haddr_i[PMSC_ADDR_W-1:0]};
    end
  end

  assign wr_en       = req_valid_reg && req_reg.write;
  assign wbyte       = hwdata_i[7:0];
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  logic wr_supv;
  logic wr_warn;
  logic wr_ista;
  logic wr_imsk;
  assign wr_supv = wr_en && addr_is(req_reg.addr, PMSC_SUPV_OFFS);
  assign wr_warn = wr_en && addr_is(req_reg.addr, PMSC_WARN_OFFS);
  assign wr_ista = wr_en && addr_is(req_reg.addr, PMSC_ISTA_OFFS);
  assign wr_imsk = wr_en && addr_is(req_reg.addr, PMSC_IMSK_OFFS);

  // supervision register storage
  logic uv_flag_reg;
  logic uv_ie_reg;
  logic uv_re_reg;
  logic uv_se_reg;
  logic uv_de_reg;
  logic reference_buffer_enable_reg;
  logic supv_written_reg;
  logic uv_active;
  logic uv_event;
  logic uv_prev_reg;

  // detection runs when enabled and, in stop, only with stop enable
  assign uv_active = uv_de_reg && (!ana.in_stop || uv_se_reg);
  assign uv_event  = uv_active && ana.undervolt && !uv_prev_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      uv_prev_reg <= 1'b0;
    end else begin
      uv_prev_reg <= uv_active && ana.undervolt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      uv_flag_reg <= 1'b0;
    end else if (uv_event) begin
      uv_flag_reg <= 1'b1;
    end else if (wr_supv && wbyte[PMSC_UVACK_BIT]) begin
      uv_flag_reg <= 1'b0;
    end
  end

  // reset enable and detector enable are the write-once fields; others stay writable
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      uv_ie_reg        <= PMSC_SUPV_RST[PMSC_UVIE_BIT];
      uv_re_reg        <= PMSC_SUPV_RST[PMSC_UVRE_BIT];
      uv_se_reg        <= PMSC_SUPV_RST[PMSC_UVSE_BIT];
      uv_de_reg        <= PMSC_SUPV_RST[PMSC_UVDE_BIT];
      reference_buffer_enable_reg         <= PMSC_SUPV_RST[PMSC_REFERENCE_BUFFER_ENABLE_BIT];
      supv_written_reg <= 1'b0;
    end else if (wr_supv) begin
      uv_ie_reg <= wbyte[PMSC_UVIE_BIT];
      uv_se_reg <= wbyte[PMSC_UVSE_BIT];
      reference_buffer_enable_reg  <= wbyte[PMSC_REFERENCE_BUFFER_ENABLE_BIT];
      supv_written_reg <= 1'b1;
      if (!supv_written_reg) begin
        uv_re_reg <= wbyte[PMSC_UVRE_BIT];
        uv_de_reg <= wbyte[PMSC_UVDE_BIT];
      end
    end
  end

  // warning/stop register storage
  logic sw_flag_reg;
  logic dtsel_reg;
  logic wtsel_reg;
  logic ds_flag_reg;
  logic dssel_reg;
  logic dssel_written_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sw_flag_reg <= 1'b0;
    end else begin
      if (ana.warning) begin
        sw_flag_reg <= 1'b1;
      end else if (wr_warn && wbyte[PMSC_SWACK_BIT]) begin
        sw_flag_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i && por_i) begin
      dtsel_reg <= PMSC_WARN_RST[PMSC_DTSEL_BIT];
      wtsel_reg <= PMSC_WARN_RST[PMSC_WTSEL_BIT];
    end else if (!reset_i && wr_warn) begin
      dtsel_reg <= wbyte[PMSC_DTSEL_BIT];
      wtsel_reg <= wbyte[PMSC_WTSEL_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ds_flag_reg <= 1'b0;
    end else if (ana.deep_exit) begin
      ds_flag_reg <= 1'b1;
    end else if (wr_warn && wbyte[PMSC_DSACK_BIT]) begin
      ds_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dssel_reg         <= PMSC_WARN_RST[PMSC_DSSEL_BIT];
      dssel_written_reg <= 1'b0;
    end else if (wr_warn && !dssel_written_reg) begin
      dssel_reg         <= wbyte[PMSC_DSSEL_BIT];
      dssel_written_reg <= 1'b1;
    end
  end

  // sticky interrupt status, write-one-to-clear, set wins
  logic [PMSC_EV_W-1:0] ev_set;
  logic [PMSC_EV_W-1:0] ista_reg;
  logic [PMSC_EV_W-1:0] imsk_reg;
  logic                 sw_prev_reg;
  logic                 ds_prev_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sw_prev_reg <= 1'b0;
      ds_prev_reg <= 1'b0;
    end else begin
      sw_prev_reg <= sw_flag_reg;
      ds_prev_reg <= ds_flag_reg;
    end
  end

  assign ev_set = {ds_flag_reg && !ds_prev_reg,
                   sw_flag_reg && !sw_prev_reg,
                   uv_event};

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ista_reg <= PMSC_EV_RST;
    end else begin
      ista_reg <= ev_set |
                  (ista_reg & ~(wr_ista ? wbyte[PMSC_EV_W-1:0] : 3'h0));
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      imsk_reg <= PMSC_EV_RST;
    end else if (wr_imsk) begin
      imsk_reg <= wbyte[PMSC_EV_W-1:0];
    end
  end

  // read mux; ack bits and reserved bit read zero
  logic [7:0] supv_rd;
  logic [7:0] warn_rd;
  logic [31:0] rd_next;

  always_comb begin
    supv_rd = 8'h00;
    supv_rd[PMSC_UVF_BIT]  = uv_flag_reg;
    supv_rd[PMSC_UVIE_BIT] = uv_ie_reg;
    supv_rd[PMSC_UVRE_BIT] = uv_re_reg;
    supv_rd[PMSC_UVSE_BIT] = uv_se_reg;
    supv_rd[PMSC_UVDE_BIT] = uv_de_reg;
    supv_rd[PMSC_REFERENCE_BUFFER_ENABLE_BIT] = reference_buffer_enable_reg;
    warn_rd = 8'h00;
    warn_rd[PMSC_SWF_BIT]   = sw_flag_reg;
    warn_rd[PMSC_DTSEL_BIT] = dtsel_reg;
    warn_rd[PMSC_WTSEL_BIT] = wtsel_reg;
    warn_rd[PMSC_DSF_BIT]   = ds_flag_reg;
    warn_rd[PMSC_DSSEL_BIT] = dssel_reg;
  end

  always_comb begin
    rd_next = 32'h0000_0000;
    if (addr_is(haddr_i[PMSC_ADDR_W-1:0], PMSC_SUPV_OFFS)) begin
      rd_next = {24'h00_0000, supv_rd};
    end else if (addr_is(haddr_i[PMSC_ADDR_W-1:0], PMSC_WARN_OFFS)) begin
      rd_next = {24'h00_0000, warn_rd};
    end else if (addr_is(haddr_i[PMSC_ADDR_W-1:0], PMSC_ISTA_OFFS)) begin
      rd_next = {29'h0000_0000, ista_reg};
    end else if (addr_is(haddr_i[PMSC_ADDR_W-1:0], PMSC_IMSK_OFFS)) begin
      rd_next = {29'h0000_0000, imsk_reg};
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (addr_take && !hwrite_i) begin
      hrdata_o <= rd_next;
    end
  end

  // outputs to analog and system logic
  logic uv_reset_reg;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      uv_reset_reg <= 1'b0;
    end else begin
      uv_reset_reg <= uv_event && uv_re_reg && uv_de_reg;
    end
  end

  assign undervolt_reset_o   = uv_reset_reg;
  assign undervolt_irq_o     = uv_flag_reg && uv_ie_reg;
  assign detector_on_o       = uv_active;
  assign detect_threshold_o  = dtsel_reg;
  assign warning_threshold_o = wtsel_reg;
  assign reference_buffer_o  = reference_buffer_enable_reg;
  assign deep_stop_mode_o    = dssel_reg;
  assign irq_o               = |(ista_reg & imsk_reg);

endmodule

`default_nettype wire

//--- verification/pmsc_top_assertions.sv
// pmsc_top_assertions: port checks for pmsc_top.
// assumes one bus clock; bound to every pmsc_top.
`timescale 1ns/1ps
`default_nettype none
module pmsc_checker (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hsel_i,
  input wire logic        hready_i,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic        undervolt_cmp_i,
  input wire logic        undervolt_irq_o,
  input wire logic        undervolt_reset_o,
  input wire logic        detect_threshold_o,
  input wire logic        warning_threshold_o,
  input wire logic        reference_buffer_o,
  input wire logic        deep_stop_mode_o,
  input wire logic        irq_o
);
  logic wr_dp;
  always_ff @(posedge clk_i) begin
    wr_dp <= hsel_i && hready_i && htrans_i[1] && hwrite_i && !reset_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  zero_wait_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready or not okay");
  rst_pulse_a: assert property (undervolt_reset_o |=> !undervolt_reset_o)
    else $error("reset request longer than one cycle");
  rst_cause_a: assert property (!undervolt_cmp_i [*8] |=> !undervolt_reset_o)
    else $error("reset request without comparator");
  irq_fall_a: assert property ($fell(irq_o) |-> $past(wr_dp))
    else $error("irq dropped without a write");
  uv_irq_fall_a: assert property ($fell(undervolt_irq_o) |-> $past(wr_dp))
    else $error("detect irq dropped without a write");
  dthr_src_a: assert property ($changed(detect_threshold_o) |-> $past(wr_dp))
    else $error("detect threshold moved alone");
  wthr_src_a: assert property ($changed(warning_threshold_o) |-> $past(wr_dp))
    else $error("warning threshold moved alone");
  refb_src_a: assert property ($changed(reference_buffer_o) |-> $past(wr_dp))
    else $error("buffer enable moved alone");
  dsel_src_a: assert property ($changed(deep_stop_mode_o) |-> $past(wr_dp))
    else $error("stop select moved alone");
  cover property ($rose(undervolt_reset_o));
  cover property ($rose(irq_o));
  cover property ($fell(undervolt_irq_o));
endmodule
bind pmsc_top pmsc_checker u_chk (.*);
`default_nettype wire

//--- verification/tb_pmsc_top.sv
// tb_pmsc_top: self-checking bench with a register model.
// assumes the bench is the only bus master and drives all pins.
`timescale 1ns/1ps
`default_nettype none
module tb_pmsc_top
  import pmsc_pkg::*;
;
  logic        clk_i, reset_i, por_i, hwrite_i, hsel_i, rdy, resp;
  logic [31:0] haddr_i, hwdata_i, hrdata_o;
  logic [1:0]  htrans_i;
  logic        uvc, wc, dx, stp, uvi, uvr, don, dt, wt, rb, ds, irq;
  logic [7:0]  m_sup, m_wrn, d;
  logic [2:0]  m_sta, m_msk;
  logic        s_lk, d_lk;
  int          miscompares, num_checks, rcnt;
  pmsc_top dut (.clk_i(clk_i), .reset_i(reset_i), .por_i(por_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(PMSC_HSIZE_WORD), .hwdata_i(hwdata_i), .hsel_i(hsel_i),
    .hready_i(rdy), .hrdata_o(hrdata_o), .hreadyout_o(rdy),
    .hresp_o(resp), .undervolt_cmp_i(uvc), .warning_cmp_i(wc),
    .deep_exit_i(dx), .in_stop_i(stp), .undervolt_irq_o(uvi),
    .undervolt_reset_o(uvr), .detector_on_o(don),
    .detect_threshold_o(dt), .warning_threshold_o(wt),
    .reference_buffer_o(rb), .deep_stop_mode_o(ds), .irq_o(irq));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (uvr === 1'b1) rcnt++;
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic bus(logic [11:0] a, logic w, logic [7:0] v,
                     output logic [31:0] q);
    @(posedge clk_i);
    haddr_i <= {20'h0_0000, a};
    htrans_i <= PMSC_HTRANS_NONSEQ;
    hwrite_i <= w;
    do begin
      @(posedge clk_i);
    end while (rdy !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= {24'h00_0000, v};
    do begin
      @(posedge clk_i);
    end while (rdy !== 1'b1);
    q = hrdata_o;
  endtask
  task automatic wr(logic [11:0] a, logic [7:0] v);
    logic [31:0] q;
    bus(a, 1'b1, v, q);
    case (a)
      PMSC_SUPV_OFFS: begin
        if (v[6]) m_sup[7] = 1'b0;
        {m_sup[5], m_sup[3], m_sup[0]} = {v[5], v[3], v[0]};
        if (!s_lk) {m_sup[4], m_sup[2]} = {v[4], v[2]};
        s_lk = 1'b1;
      end
      PMSC_WARN_OFFS: begin
        if (v[6] && !wc) m_wrn[7] = 1'b0;
        if (v[2]) m_wrn[3] = 1'b0;
        m_wrn[5:4] = v[5:4];
        if (!d_lk) m_wrn[0] = v[0];
        d_lk = 1'b1;
      end
      PMSC_ISTA_OFFS: m_sta &= ~v[2:0];
      PMSC_IMSK_OFFS: m_msk = v[2:0];
      default: ;
    endcase
  endtask
  task automatic rd(logic [11:0] a, logic [7:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 8'h00, q);
    chk("register", {24'h00_0000, e}, q);
  endtask
  task automatic sweep;
    rd(PMSC_SUPV_OFFS, m_sup);
    rd(PMSC_WARN_OFFS, m_wrn);
    rd(PMSC_ISTA_OFFS, {5'h00, m_sta});
    rd(PMSC_IMSK_OFFS, {5'h00, m_msk});
    chk("pins", {m_sup[7] & m_sup[5], |(m_sta & m_msk),
      m_sup[2] & !(stp & !m_sup[3]), m_wrn[5:4], m_sup[0], m_wrn[0]},
      {uvi, irq, don, dt, wt, rb, ds});
  endtask
  task automatic rst(logic p);
    reset_i <= 1'b1;
    por_i <= p;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    m_sup = PMSC_SUPV_RST;
    m_wrn = p ? 8'h00 : (m_wrn & 8'h30);
    {m_sta, m_msk, s_lk, d_lk} = '0;
  endtask
  task automatic settle;
    repeat (10) @(posedge clk_i);
  endtask
  task automatic finish_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    finish_test();
  end
  initial begin
    {reset_i, por_i, hwrite_i, hsel_i} = 4'h9;
    {uvc, wc, dx, stp, htrans_i, haddr_i, hwdata_i} = '0;
    void'($urandom(32'h3d2eae7f));
    rst(1'b1);
    hsel_i <= 1'b1;
    sweep();
    rd(12'h010, 8'h00);
    d = 8'h34 | (8'($urandom) & 8'h09);
    wr(PMSC_SUPV_OFFS, d);
    wr(PMSC_IMSK_OFFS, 8'h07);
    uvc <= 1'b1;
    settle();
    {m_sup[7], m_sta[0]} = 2'b11;
    sweep();
    chk("reset pulses", 1, rcnt);
    wr(PMSC_SUPV_OFFS, d | 8'h40);
    wr(PMSC_ISTA_OFFS, 8'h01);
    wr(PMSC_SUPV_OFFS, d & 8'h29);
    sweep();
    uvc <= 1'b0;
    stp <= 1'b1;
    wr(PMSC_SUPV_OFFS, 8'h20);
    uvc <= 1'b1;
    settle();
    sweep();
    uvc <= 1'b0;
    settle();
    stp <= 1'b0;
    rst(1'b0);
    wr(PMSC_WARN_OFFS, 8'h31);
    sweep();
    rst(1'b0);
    sweep();
    wr(PMSC_SUPV_OFFS, 8'h20);
    uvc <= 1'b1;
    wc <= 1'b1;
    settle();
    {m_wrn[7], m_sta[1]} = 2'b11;
    wr(PMSC_WARN_OFFS, 8'h71);
    sweep();
    chk("reset pulses", 1, rcnt);
    {uvc, wc} <= 2'b00;
    settle();
    wr(PMSC_WARN_OFFS, 8'h70);
    dx <= 1'b1;
    settle();
    dx <= 1'b0;
    {m_wrn[3], m_sta[2]} = 2'b11;
    sweep();
    wr(PMSC_WARN_OFFS, 8'h34);
    wr(PMSC_ISTA_OFFS, 8'h06);
    sweep();
    dx <= 1'b1;
    @(posedge clk_i);
    dx <= 1'b0;
    settle();
    sweep();
    rst(1'b1);
    sweep();
    finish_test();
  end
endmodule
`default_nettype wire
